// file: hw/rari_pkg.sv
// Shared constants for the reset and interrupt response block.
package rari_pkg;
	// ==========================================================
	// Machine-cycle phasing
	// ==========================================================
	// Core clock period in picoseconds (200 MHz).
	localparam int             CORE_CLK_PS      = 5000;
	// Core clock cycles in one first-phase clock period.
	localparam int             PHASE_CYCLES     = 4;
	// Phase count at which the first-phase clock rises.
	localparam logic [1:0]     FIRST_RISE_PHASE = 2'h0;
	// Phase count at which the first-phase clock falls and the third rises.
	localparam logic [1:0]     THIRD_RISE_PHASE = 2'h2;

	// ==========================================================
	// Reset defaults and counts
	// ==========================================================
	// Software wait states loaded into both bus control registers.
	localparam logic [2:0]     RESET_WAIT       = 3'h7;
	// Wait states used by a vector fetch in microcomputer mode.
	localparam logic [2:0]     NO_WAIT          = 3'h0;
	// Number of reset vector fetches after reset.
	localparam logic [1:0]     VECTOR_FETCHES   = 2'h2;
	// Idle value of synchronised active-low inputs.
	localparam logic [5:0]     SYNC_IDLE        = 6'h3F;

	// Boot sequencer states.
	typedef enum logic [1:0] {
		BOOT_IDLE,
		BOOT_STROBE,
		BOOT_WAIT,
		BOOT_DONE
	} rari_boot_t;
endpackage : rari_pkg

// file: hw/rari_sync.sv
// Two-flip-flop synchroniser for the asynchronous input pins.
`timescale 1ns/10ps
`default_nettype none
module rari_sync #(
	parameter int         WIDTH = 6,
	parameter logic [5:0] IDLE  = 6'h3F
) (
	// Clock and reset.
	input  wire logic             core_clk,
	input  wire logic             rst,
	// Raw asynchronous pins.
	input  wire logic [WIDTH-1:0] asyncIn,
	// Synchronised copy.
	output logic      [WIDTH-1:0] syncOut
);
	// ==========================================================
	// Metastability stages
	// ==========================================================
	// First stage; only the second stage reads it.
	logic [WIDTH-1:0] stage1_q;

	// Both stages reset to the idle (inactive-high) level of the pins.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			stage1_q <= IDLE[WIDTH-1:0];
			syncOut  <= IDLE[WIDTH-1:0];
		end else begin
			stage1_q <= asyncIn;
			syncOut  <= stage1_q;
		end
	end
endmodule : rari_sync
`default_nettype wire

// file: hw/rari_top.sv
// Reset and interrupt response logic: pin release, bus defaults, boot fetch, irq, ack.
// How it works
// - Reset taken anytime; may slip one cycle
// - Flag, serial, timer pins float during reset
// - Reset loads seven wait states both buses
// - Hold request honoured even during reset
// - Microprocessor boot: two fetches, seven waits
// - Microcomputer boot: two fetches, zero waits
// - Read/write output floats throughout reset
// - Data floats first-phase rise, address third-phase rise
// - Bus controls driven high at third-phase rise
// - Irq lines level sensitive, accepted anytime out of reset
// - Irq lines sampled low at H1 fall
// - Core and DMA act at fetch boundaries
// - Same line re-accepted every two cycles
// - Ack low at decode, high at read
// - Ack low one cycle despite stretched decode
`timescale 1ns/10ps
`default_nettype none
module rari_top #(
	parameter int IRQ_LINES = 4
) (
	// Clock and core reset.
	input  wire logic                 core_clk,
	input  wire logic                 rst,
	// Asynchronous pins from the system.
	input  wire logic                 resetPinN,
	input  wire logic                 holdReqN,
	input  wire logic [IRQ_LINES-1:0] extIrqN,
	// Boot strap: high selects microcomputer mode.
	input  wire logic                 bootMicrocomputer,
	// Peripheral drive requests for the reset-released pins.
	input  wire logic [1:0]           flagDriveEn,
	input  wire logic [5:0]           serialDriveEn,
	input  wire logic [1:0]           timerDriveEn,
	// Bus drive requests from the memory interface.
	input  wire logic                 busDataDriveEn,
	input  wire logic                 busAddrDriveEn,
	input  wire logic                 busRwDriveEn,
	// Software write of the bus control wait fields.
	input  wire logic                 waitWrite,
	input  wire logic [2:0]           primaryWaitIn,
	input  wire logic [2:0]           expansionWaitIn,
	// Pipeline status.
	input  wire logic                 cpuFetchBoundary,
	input  wire logic                 dmaFetchBoundary,
	input  wire logic                 ackInDecode,
	// Pin output enables, low while driving.
	output logic      [1:0]           flagOeN,
	output logic      [5:0]           serialOeN,
	output logic      [1:0]           timerOeN,
	output logic                      dataOeN,
	output logic                      addrOeN,
	output logic                      rwOeN,
	// Bus control and hold.
	output logic                      extStrobeN,
	output logic                      holdAckN,
	output logic      [2:0]           primaryWait,
	output logic      [2:0]           expansionWait,
	output logic      [1:0]           vectorFetchCount,
	// Interrupt delivery and acknowledge.
	output logic      [IRQ_LINES-1:0] cpuIrqTake,
	output logic      [IRQ_LINES-1:0] dmaIrqTake,
	output logic                      irqAckN
);
	// ==========================================================
	// Input synchronisation and phase enables
	// ==========================================================
	logic [5:0]           syncPins;      // Synchronised reset, hold and irq pins.
	logic [1:0]           phase_q;       // Position inside the first-phase clock period.
	logic                 firstRise;     // First-phase clock rising enable.
	logic                 firstFall;     // First-phase falling (third-phase rising) enable.
	logic                 inReset_q;     // Device held in reset.
	logic                 holdSync;      // Synchronised hold request, active high.
	logic [IRQ_LINES-1:0] irqLow;        // Synchronised irq lines found low.

	// Reset, hold and irq pins pass two flops; a missed setup window costs one cycle.
	rari_sync #(
		.WIDTH (6),
		.IDLE  (rari_pkg::SYNC_IDLE)
	) u_sync (
		.core_clk (core_clk),
		.rst      (rst),
		.asyncIn  ({extIrqN, holdReqN, resetPinN}),
		.syncOut  (syncPins)
	);

	assign holdSync  = ~syncPins[1];
	assign irqLow    = ~syncPins[5:2];
	assign firstRise = (phase_q == rari_pkg::FIRST_RISE_PHASE);
	assign firstFall = (phase_q == rari_pkg::THIRD_RISE_PHASE);

	// Free-running divider that marks the phase-clock edges.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			phase_q <= 2'h0;
		end else begin
			phase_q <= phase_q + 2'h1;
		end
	end

	// Reset pin is sampled only on first-phase falling edges.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			inReset_q <= 1'b1;
		end else if (firstFall) begin
			inReset_q <= ~syncPins[0];
		end
	end

	// ==========================================================
	// Pin release and bus floating
	// ==========================================================
	// Peripheral pins float at once in reset, else follow their owners.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			flagOeN   <= 2'h3;
			serialOeN <= 6'h3F;
			timerOeN  <= 2'h3;
		end else if (inReset_q) begin
			flagOeN   <= 2'h3;
			serialOeN <= 6'h3F;
			timerOeN  <= 2'h3;
		end else begin
			flagOeN   <= ~flagDriveEn;
			serialOeN <= ~serialDriveEn;
			timerOeN  <= ~timerDriveEn;
		end
	end

	// Read/write floats for all of reset; an external pull-up holds it.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			rwOeN <= 1'b1;
		end else begin
			rwOeN <= inReset_q | holdSync | ~busRwDriveEn;
		end
	end

	// Data lets go on a first-phase rise, address on a third-phase rise.
	// Hold floats both buses whether or not reset is active.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			dataOeN <= 1'b1;
			addrOeN <= 1'b1;
		end else begin
			if (firstRise || !inReset_q) begin
				dataOeN <= inReset_q | holdSync | ~busDataDriveEn;
			end
			if (firstFall || !inReset_q) begin
				addrOeN <= inReset_q | holdSync | ~busAddrDriveEn;
			end
		end
	end

	// Hold acknowledge follows the request with reset ignored.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			holdAckN <= 1'b1;
		end else begin
			holdAckN <= ~holdSync;
		end
	end

	// ==========================================================
	// Wait states and boot vector fetch
	// ==========================================================
	rari_pkg::rari_boot_t bootState_q;  // Boot sequencer state.
	logic [2:0]           waitCnt_q;    // Wait states left in the current fetch.

	// Reset forces seven waits on both buses until software rewrites them.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			primaryWait   <= rari_pkg::RESET_WAIT;
			expansionWait <= rari_pkg::RESET_WAIT;
		end else if (inReset_q) begin
			primaryWait   <= rari_pkg::RESET_WAIT;
			expansionWait <= rari_pkg::RESET_WAIT;
		end else if (waitWrite) begin
			primaryWait   <= primaryWaitIn;
			expansionWait <= expansionWaitIn;
		end
	end

	// Two vector fetches, stepped on first-phase rises; the strap picks waits.
	// The strobe is forced high on a third-phase rise while in reset.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			bootState_q      <= rari_pkg::BOOT_IDLE;
			waitCnt_q        <= 3'h0;
			vectorFetchCount <= 2'h0;
			extStrobeN       <= 1'b1;
		end else if (inReset_q) begin
			bootState_q      <= rari_pkg::BOOT_IDLE;
			vectorFetchCount <= 2'h0;
			if (firstFall) begin
				extStrobeN <= 1'b1;
			end
		end else if (firstRise && !holdSync) begin
			case (bootState_q)
				rari_pkg::BOOT_IDLE: begin
					// Open a fetch; microcomputer mode uses no waits.
					extStrobeN  <= 1'b0;
					waitCnt_q   <= bootMicrocomputer ? rari_pkg::NO_WAIT : primaryWait;
					bootState_q <= rari_pkg::BOOT_WAIT;
				end
				rari_pkg::BOOT_WAIT: begin
					if (waitCnt_q != 3'h0) begin
						waitCnt_q <= waitCnt_q - 3'h1;
					end else begin
						extStrobeN       <= 1'b1;
						vectorFetchCount <= vectorFetchCount + 2'h1;
						bootState_q      <= rari_pkg::BOOT_STROBE;
					end
				end
				rari_pkg::BOOT_STROBE: begin
					// Second fetch, or finish once both are done.
					if (vectorFetchCount == rari_pkg::VECTOR_FETCHES) begin
						bootState_q <= rari_pkg::BOOT_DONE;
					end else begin
						bootState_q <= rari_pkg::BOOT_IDLE;
					end
				end
				rari_pkg::BOOT_DONE: begin
					extStrobeN <= 1'b1;
				end
				default: begin
					bootState_q <= rari_pkg::BOOT_DONE;
				end
			endcase
		end
	end

	// ==========================================================
	// Interrupt detection and delivery
	// ==========================================================
	logic [IRQ_LINES-1:0] lock_q;     // Line detected on the previous falling edge.
	logic [IRQ_LINES-1:0] cpuPend_q;  // Detections awaiting the core.
	logic [IRQ_LINES-1:0] dmaPend_q;  // Detections awaiting the DMA channel.
	logic [IRQ_LINES-1:0] newIrq;     // Fresh detection this cycle.

	// Levels, not edges, count; a low seen at a first-phase fall detects.
	// A detection blocks the next fall, so a pulse of one or two edges
	// gives one interrupt and a line is re-accepted every two cycles.
	assign newIrq = (firstFall && !inReset_q) ? (irqLow & ~lock_q) : '0;

	// Lockout of one falling edge after each detection.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			lock_q <= '0;
		end else if (firstFall) begin
			lock_q <= newIrq;
		end
	end

	// Pending flags: a new detection wins over a take in the same cycle.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			cpuPend_q  <= '0;
			dmaPend_q  <= '0;
			cpuIrqTake <= '0;
			dmaIrqTake <= '0;
		end else begin
			cpuIrqTake <= cpuFetchBoundary ? cpuPend_q : '0;
			dmaIrqTake <= dmaFetchBoundary ? dmaPend_q : '0;
			cpuPend_q  <= (cpuFetchBoundary ? '0 : cpuPend_q) | newIrq;
			dmaPend_q  <= (dmaFetchBoundary ? '0 : dmaPend_q) | newIrq;
		end
	end

	// ==========================================================
	// Interrupt acknowledge
	// ==========================================================
	logic ackDone_q;  // Acknowledge already given for this decode.

	// Low at the rise opening decode, high at the next rise, once per decode.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			irqAckN   <= 1'b1;
			ackDone_q <= 1'b0;
		end else if (inReset_q) begin
			irqAckN   <= 1'b1;
			ackDone_q <= 1'b0;
		end else if (firstRise) begin
			irqAckN   <= ~(ackInDecode && !ackDone_q);
			ackDone_q <= ackInDecode;
		end
	end

	// ==========================================================
	// Checks
	// ==========================================================
	sequence s_ackLow;
		(!irqAckN) [*4];
	endsequence
	sequence s_ackHigh;
		irqAckN;
	endsequence

	property p_pinsFloat;
		@(posedge core_clk) disable iff (rst)
		inReset_q |=> (&flagOeN && &serialOeN && &timerOeN);
	endproperty
	a_pinsFloat: assert property (p_pinsFloat) else $error("pins driven in reset");

	property p_rwFloat;
		@(posedge core_clk) disable iff (rst)
		inReset_q |=> rwOeN;
	endproperty
	a_rwFloat: assert property (p_rwFloat) else $error("rw driven in reset");

	property p_waitReset;
		@(posedge core_clk) disable iff (rst)
		inReset_q |=> (primaryWait == 3'h7 && expansionWait == 3'h7);
	endproperty
	a_waitReset: assert property (p_waitReset) else $error("wait not seven");

	property p_hold;
		@(posedge core_clk) disable iff (rst)
		$fell(holdReqN) ##1 !holdReqN [*3] |-> !holdAckN && dataOeN [*1];
	endproperty
	a_hold: assert property (p_hold) else $error("hold not honoured");

	property p_dataFloat;
		@(posedge core_clk) disable iff (rst)
		(inReset_q && firstRise) |=> dataOeN;
	endproperty
	a_dataFloat: assert property (p_dataFloat) else $error("data not floated");

	property p_strobeHigh;
		@(posedge core_clk) disable iff (rst)
		(inReset_q && firstFall) |=> extStrobeN;
	endproperty
	a_strobeHigh: assert property (p_strobeHigh) else $error("strobe low in reset");

	property p_detect;
		@(posedge core_clk) disable iff (rst)
		(firstFall && !inReset_q && irqLow[0] && !lock_q[0]) |=> cpuPend_q[0];
	endproperty
	a_detect: assert property (p_detect) else $error("irq not detected");

	property p_lockout;
		@(posedge core_clk) disable iff (rst)
		newIrq[0] |-> ##4 !newIrq[0];
	endproperty
	a_lockout: assert property (p_lockout) else $error("irq double taken");

	property p_take;
		@(posedge core_clk) disable iff (rst)
		(cpuIrqTake != '0) |-> $past(cpuFetchBoundary);
	endproperty
	a_take: assert property (p_take) else $error("irq taken off boundary");

	property p_ackOne;
		@(posedge core_clk) disable iff (rst || inReset_q)
		$fell(irqAckN) |-> s_ackLow ##1 s_ackHigh;
	endproperty
	a_ackOne: assert property (p_ackOne) else $error("ack width wrong");

	property p_ackEdge;
		@(posedge core_clk) disable iff (rst)
		$fell(irqAckN) |-> $past(firstRise) && $past(ackInDecode);
	endproperty
	a_ackEdge: assert property (p_ackEdge) else $error("ack off phase");
endmodule : rari_top
`default_nettype wire

// file: sim/rari_sys_model.sv
// System-side model that drives the reset, hold and interrupt pins.
`timescale 1ns/10ps
`default_nettype none
module rari_sys_model (
	// Clock.
	input  wire logic       core_clk,
	// Pins towards the device.
	output var  logic       resetPinN,
	output var  logic       holdReqN,
	output var  logic [3:0] extIrqN
);
	// ==========================================================
	// Pin drivers
	// ==========================================================
	// The system holds the device in reset from power-up; other pins idle high.
	initial begin
		resetPinN = 1'b0;
		holdReqN  = 1'b1;
		extIrqN   = 4'hF;
	end

	// Reset may move at any cycle; the device copes with the slip.
	task setReset(input logic v);
		@(posedge core_clk) resetPinN <= v;
	endtask : setReset

	// Hold may be requested while reset is still applied.
	task setHold(input logic v);
		@(posedge core_clk) holdReqN <= v;
	endtask : setHold

	// One request line low for a set number of cycles, then released.
	// Callers keep the width within one or two sampling edges for one event.
	task pulseIrq(input int line, input int cycles);
		@(posedge core_clk) extIrqN[line] <= 1'b0;
		repeat (cycles) @(posedge core_clk);
		extIrqN[line] <= 1'b1;
	endtask : pulseIrq
endmodule : rari_sys_model
`default_nettype wire

// file: sim/tb_rari_top.sv
// Self-checking testbench for the reset and interrupt response block.
`timescale 1ns/10ps
`default_nettype none
module tb_rari_top;
	// ==========================================================
	// Signals
	// ==========================================================
	logic       core_clk;
	logic       rst;
	wire logic  resetPinN;
	wire logic  holdReqN;
	wire logic  [3:0] extIrqN;
	logic       bootMicrocomputer;
	logic [1:0] flagDriveEn;
	logic [5:0] serialDriveEn;
	logic [1:0] timerDriveEn;
	logic       busDataDriveEn;
	logic       busAddrDriveEn;
	logic       busRwDriveEn;
	logic       waitWrite;
	logic [2:0] primaryWaitIn;
	logic [2:0] expansionWaitIn;
	logic       cpuFetchBoundary;
	logic       dmaFetchBoundary;
	logic       ackInDecode;
	logic [1:0] flagOeN;
	logic [5:0] serialOeN;
	logic [1:0] timerOeN;
	logic       dataOeN;
	logic       addrOeN;
	logic       rwOeN;
	logic       extStrobeN;
	logic       holdAckN;
	logic [2:0] primaryWait;
	logic [2:0] expansionWait;
	logic [1:0] vectorFetchCount;
	logic [3:0] cpuIrqTake;
	logic [3:0] dmaIrqTake;
	logic       irqAckN;
	int         err_total = 0;
	int         n_tests   = 0;
	int         cpuCnt [4];
	int         dmaCnt [4];

	// ==========================================================
	// Instances
	// ==========================================================
	rari_sys_model rari_sys_model_i (.core_clk(core_clk), .resetPinN(resetPinN),
		.holdReqN(holdReqN), .extIrqN(extIrqN));
	rari_top #(.IRQ_LINES(4)) rari_top_i (.core_clk(core_clk), .rst(rst),
		.resetPinN(resetPinN), .holdReqN(holdReqN), .extIrqN(extIrqN),
		.bootMicrocomputer(bootMicrocomputer), .flagDriveEn(flagDriveEn),
		.serialDriveEn(serialDriveEn), .timerDriveEn(timerDriveEn),
		.busDataDriveEn(busDataDriveEn), .busAddrDriveEn(busAddrDriveEn),
		.busRwDriveEn(busRwDriveEn), .waitWrite(waitWrite), .primaryWaitIn(primaryWaitIn),
		.expansionWaitIn(expansionWaitIn), .cpuFetchBoundary(cpuFetchBoundary),
		.dmaFetchBoundary(dmaFetchBoundary), .ackInDecode(ackInDecode),
		.flagOeN(flagOeN), .serialOeN(serialOeN), .timerOeN(timerOeN), .dataOeN(dataOeN),
		.addrOeN(addrOeN), .rwOeN(rwOeN), .extStrobeN(extStrobeN), .holdAckN(holdAckN),
		.primaryWait(primaryWait), .expansionWait(expansionWait),
		.vectorFetchCount(vectorFetchCount), .cpuIrqTake(cpuIrqTake),
		.dmaIrqTake(dmaIrqTake), .irqAckN(irqAckN));

	// ==========================================================
	// Clock and take counters
	// ==========================================================
	// Half period of 2.5 ns gives the 200 MHz core clock.
	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end

	// Take pulses last one cycle, so every high sample is one delivery.
	always @(posedge core_clk) begin
		for (int k = 0; k < 4; k++) begin
			if (cpuIrqTake[k] === 1'b1) cpuCnt[k]++;
			if (dmaIrqTake[k] === 1'b1) dmaCnt[k]++;
		end
	end

	// ==========================================================
	// Helpers
	// ==========================================================
	// Step past edges; the extra 1 ns lets registered outputs settle.
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask : cyc

	task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask : check

	task automatic test_done();
		$display("Comparisons %0d, mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : test_done

	// ==========================================================
	// Scenarios
	// ==========================================================
	// In device reset every pin floats and strobe idles high, though all
	// drive requests are raised; both wait fields show the slow default.
	task automatic t_reset_float();
		cyc(6);
		check("floatPins", 16'h3FFF, {2'h0, flagOeN, serialOeN, timerOeN, dataOeN,
			addrOeN, rwOeN, extStrobeN});
		check("waits", {10'h0, rari_pkg::RESET_WAIT, rari_pkg::RESET_WAIT},
			{10'h0, primaryWait, expansionWait});
	endtask : t_reset_float

	// Hold is granted within a bounded time and the buses float meanwhile.
	task automatic t_hold();
		int i;
		rari_sys_model_i.setHold(1'b0);
		for (i = 0; i < 8 && holdAckN !== 1'b0; i++) cyc(1);
		check("holdAckN", 16'h0000, {15'h0, holdAckN});
		check("busFloat", 16'h0003, {14'h0, dataOeN, addrOeN});
		rari_sys_model_i.setHold(1'b1);
		cyc(8);
		check("holdRelease", 16'h0001, {15'h0, holdAckN});
	endtask : t_hold

	// Reset release: two vector fetches whose strobe width follows the mode.
	task automatic t_boot(input logic mc);
		int i;
		int n;
		logic [15:0] exp;
		exp = 16'(((mc ? rari_pkg::NO_WAIT : rari_pkg::RESET_WAIT) + 1) * rari_pkg::PHASE_CYCLES);
		@(posedge core_clk) bootMicrocomputer <= mc;
		rari_sys_model_i.setReset(1'b1);
		cyc(1);
		for (int f = 0; f < 2; f++) begin
			n = 0;
			for (i = 0; i < 40 && extStrobeN !== 1'b0; i++) cyc(1);
			while (extStrobeN === 1'b0 && n < 64) begin
				cyc(1);
				n++;
			end
			check("strobeLow", exp, 16'(n));
		end
		cyc(8);
		check("fetches", 16'h0002, {14'h0, vectorFetchCount});
		check("drivePins", 16'h0000, {3'h0, flagOeN, serialOeN, timerOeN, dataOeN,
			addrOeN, rwOeN});
	endtask : t_boot

	// Delivery waits for a fetch boundary; cpu and dma take separately;
	// one event per 1..2 edge pulse, a long pulse re-accepted every 2nd edge.
	task automatic t_irq();
		cpuCnt = '{0, 0, 0, 0};
		dmaCnt = '{0, 0, 0, 0};
		rari_sys_model_i.pulseIrq(1, 4);
		cyc(12);
		check("takeEarly", 16'h0000, 16'(cpuCnt[1] + dmaCnt[1]));
		@(posedge core_clk) cpuFetchBoundary <= 1'b1;
		@(posedge core_clk) cpuFetchBoundary <= 1'b0;
		cyc(2);
		check("cpuTake", 16'h0001, 16'(cpuCnt[1]));
		check("dmaPending", 16'h0000, 16'(dmaCnt[1]));
		@(posedge core_clk) dmaFetchBoundary <= 1'b1;
		@(posedge core_clk) dmaFetchBoundary <= 1'b0;
		cyc(2);
		check("dmaTake", 16'h0001, 16'(dmaCnt[1]));
		cpuCnt = '{0, 0, 0, 0};
		dmaCnt = '{0, 0, 0, 0};
		@(posedge core_clk) cpuFetchBoundary <= 1'b1;
		dmaFetchBoundary <= 1'b1;
		for (int k = 0; k < 4; k++) begin
			rari_sys_model_i.pulseIrq(k, 8);
			cyc(12);
			check("oneTakeCpu", 16'h0001, 16'(cpuCnt[k]));
			check("oneTakeDma", 16'h0001, 16'(dmaCnt[k]));
		end
		rari_sys_model_i.pulseIrq(2, 16);
		cyc(12);
		check("reaccept", 16'h0003, 16'(cpuCnt[2]));
		@(posedge core_clk) cpuFetchBoundary <= 1'b0;
		dmaFetchBoundary <= 1'b0;
	endtask : t_irq

	// Acknowledge is low four cycles however long decode lasts, and re-arms.
	task automatic t_ack(input int hold);
		int n;
		n = 0;
		@(posedge core_clk) ackInDecode <= 1'b1;
		for (int i = 0; i < hold + 8; i++) begin
			@(posedge core_clk);
			// Decode ends on a clock edge, never between edges.
			if (i + 1 == hold) ackInDecode <= 1'b0;
			#1;
			if (irqAckN === 1'b0) n++;
		end
		check("ackLow", 16'(rari_pkg::PHASE_CYCLES), 16'(n));
	endtask : t_ack

	// Software waits load, then a reset pin assertion restores the defaults.
	task automatic t_wait_reset();
		@(posedge core_clk) waitWrite <= 1'b1;
		primaryWaitIn   <= 3'h3;
		expansionWaitIn <= 3'h5;
		@(posedge core_clk) waitWrite <= 1'b0;
		cyc(2);
		check("waitsWritten", 16'h001D, {10'h0, primaryWait, expansionWait});
		rari_sys_model_i.setReset(1'b0);
		cyc(8);
		t_reset_float();
	endtask : t_wait_reset

	// ==========================================================
	// Main sequence and watchdog
	// ==========================================================
	initial begin
		rst               = 1'b1;
		bootMicrocomputer = 1'b0;
		flagDriveEn       = 2'h3;
		serialDriveEn     = 6'h3F;
		timerDriveEn      = 2'h3;
		busDataDriveEn    = 1'b1;
		busAddrDriveEn    = 1'b1;
		busRwDriveEn      = 1'b1;
		waitWrite         = 1'b0;
		primaryWaitIn     = 3'h0;
		expansionWaitIn   = 3'h0;
		cpuFetchBoundary  = 1'b0;
		dmaFetchBoundary  = 1'b0;
		ackInDecode       = 1'b0;
		repeat (8) @(posedge core_clk);
		rst <= 1'b0;
		t_reset_float();
		t_hold();
		t_boot(1'b0);
		t_hold();
		t_irq();
		t_ack(24);
		t_ack(4);
		t_wait_reset();
		t_boot(1'b1);
		test_done();
	end

	// The run needs under 1,000 cycles; 4,000 means a hang.
	initial begin
		#20000;
		err_total++;
		test_done();
	end
endmodule : tb_rari_top
`default_nettype wire
